/* hw/status_sideband.sv */
`timescale 1ns/100ps

module status_sideband #(
    parameter logic [23:0] BLINK_HALF = sideband_pkg::BLINK_HALF_CYC
) (
    input wire logic CORE_CLK_I, // Core clock, 100 MHz.
    input wire logic RST_I, // Synchronous reset, active high.
    input wire logic [sideband_pkg::ADDR_W-1:0] ADDR_I, // Register address.
    input wire logic [sideband_pkg::DATA_W-1:0] WDATA_I, // Write data.
    input wire logic WR_I, // Write strobe.
    input wire logic RD_I, // Read strobe.
    output logic [sideband_pkg::DATA_W-1:0] RDATA_O, // Read data, cycle after the strobe.
    input wire logic LINK_UP_I, // Link is up.
    input wire logic SPEED100_I, // Link runs at 100 Mb/s.
    input wire logic ACTIVITY_I, // Traffic pulse.
    input wire logic WOL_EVENT_I, // Wake-on-LAN event pulse.
    output logic FIRST_INDICATOR_OUT_N_O, // First LED, low lights it.
    output logic SECOND_INDICATOR_OUT_N_O, // Second LED, low lights it.
    output logic WAKE_EVENT_OUT_O, // Wake event, programmable polarity.
    output logic HOST_IRQ_N_O, // Interrupt to host, active low.
    input wire logic ROM_DATA_IO_I, // ROM data pin level.
    output logic ROM_DATA_IO_O, // ROM data pin drive value.
    output logic ROM_DATA_IO_OE_O, // ROM data pin drive enable.
    output logic ROM_SERIAL_CLK_O, // ROM serial clock.
    output logic ROM_SELECT_O // ROM chip select, active high.
);
    sideband_pkg::sideband_state_s st_r;
    sideband_pkg::sideband_state_s st_nxt;

    function automatic logic [8:0] rom_half_cnt(input logic [1:0] spd);
        logic [8:0] h;
        h = sideband_pkg::ROM_HALF_SLOW;
        if (spd == sideband_pkg::BUS_SPEED_FAST) begin
            h = sideband_pkg::ROM_HALF_FAST;
        end
        return h - 9'h001;
    endfunction : rom_half_cnt

    always_comb begin
        logic [sideband_pkg::IRQ_W-1:0] set_ev;
        logic [sideband_pkg::IRQ_W-1:0] clr_ev;
        logic blink_off;
        logic act_lit;
        logic speed_lit;
        logic link_act_lit;
        logic wake_on;
        set_ev = '0;
        clr_ev = '0;
        st_nxt = st_r;
        st_nxt.sync1 = ROM_DATA_IO_I;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.link_d = LINK_UP_I;
        st_nxt.rdata = '0;

        // Off half first, then on half, so even a single short frame is seen.
        blink_off = st_r.act_timer > BLINK_HALF;
        act_lit = st_r.act_timer != 24'h000000 && !blink_off;
        link_act_lit = LINK_UP_I && !blink_off;
        speed_lit = LINK_UP_I && SPEED100_I;

        if (st_r.act_timer != 24'h000000) begin
            st_nxt.act_timer = st_r.act_timer - 24'h000001;
        end else if (ACTIVITY_I) begin
            st_nxt.act_timer = BLINK_HALF << 1;
        end

        if (WOL_EVENT_I) begin
            set_ev[sideband_pkg::IRQ_WAKE_BIT] = 1'b1;
        end
        if (LINK_UP_I != st_r.link_d) begin
            set_ev[sideband_pkg::IRQ_LINK_BIT] = 1'b1;
        end

        case (st_r.rom_st)
            sideband_pkg::ROM_IDLE: begin
                st_nxt.rom_sk = 1'b0;
            end
            sideband_pkg::ROM_LOW: begin
                if (st_r.rom_half == 9'h000) begin
                    st_nxt.rom_sk = 1'b1;
                    st_nxt.rom_half = rom_half_cnt(st_r.bus_speed);
                    st_nxt.rom_st = sideband_pkg::ROM_HIGH;
                end else begin
                    st_nxt.rom_half = st_r.rom_half - 9'h001;
                end
            end
            sideband_pkg::ROM_HIGH: begin
                if (st_r.rom_half == 9'h000) begin
                    st_nxt.rom_sk = 1'b0;
                    st_nxt.rom_half = rom_half_cnt(st_r.bus_speed);
                    st_nxt.rom_shift = st_r.rom_shift << 1;
                    st_nxt.rom_bits = st_r.rom_bits - 5'h01;
                    if (st_r.rom_bits <= sideband_pkg::ROM_IN_BITS) begin
                        // The ROM drives data after the falling edge; take it before the next fall.
                        st_nxt.rom_in = {st_r.rom_in[sideband_pkg::ROM_IN_LEN-2:0], st_r.sync2};
                    end
                    if (st_r.rom_bits == 5'h01) begin
                        st_nxt.rom_st = sideband_pkg::ROM_IDLE;
                        set_ev[sideband_pkg::IRQ_ROM_BIT] = 1'b1;
                    end else begin
                        st_nxt.rom_st = sideband_pkg::ROM_LOW;
                    end
                end else begin
                    st_nxt.rom_half = st_r.rom_half - 9'h001;
                end
            end
            default: begin
                st_nxt.rom_st = sideband_pkg::ROM_IDLE;
            end
        endcase

        if (WR_I) begin
            if (ADDR_I == sideband_pkg::GLOBAL_CONTROL_REG_ADDR) begin
                st_nxt.led_sel = WDATA_I[sideband_pkg::LED_SEL_BIT];
            end else if (ADDR_I == sideband_pkg::POWER_EVENT_CONTROL_REG_ADDR) begin
                st_nxt.wake_pol = WDATA_I[sideband_pkg::WAKE_POL_BIT];
            end else if (ADDR_I == sideband_pkg::BUS_SPEED_REG_ADDR) begin
                st_nxt.bus_speed = WDATA_I[1:0];
            end else if (ADDR_I == sideband_pkg::IRQ_MASK_REG_ADDR) begin
                st_nxt.irq_mask = WDATA_I[sideband_pkg::IRQ_W-1:0];
            end else if (ADDR_I == sideband_pkg::IRQ_STATUS_REG_ADDR) begin
                clr_ev = WDATA_I[sideband_pkg::IRQ_W-1:0];
            end else if (ADDR_I == sideband_pkg::ROM_CTRL_REG_ADDR) begin
                // A start while a read runs is dropped rather than corrupting the frame.
                if (WDATA_I[sideband_pkg::ROM_START_BIT] && st_r.rom_st == sideband_pkg::ROM_IDLE)
                begin
                    st_nxt.rom_shift = WDATA_I[sideband_pkg::ROM_OUT_LEN-1:0];
                    st_nxt.rom_bits = sideband_pkg::ROM_TOTAL_BITS;
                    st_nxt.rom_half = rom_half_cnt(st_r.bus_speed);
                    st_nxt.rom_st = sideband_pkg::ROM_LOW;
                end
            end
        end
        // A new event outranks a clear arriving in the same cycle.
        st_nxt.irq_stat = (st_r.irq_stat & ~clr_ev) | set_ev;

        if (RD_I) begin
            if (ADDR_I == sideband_pkg::GLOBAL_CONTROL_REG_ADDR) begin
                st_nxt.rdata[sideband_pkg::LED_SEL_BIT] = st_r.led_sel;
            end else if (ADDR_I == sideband_pkg::POWER_EVENT_CONTROL_REG_ADDR) begin
                st_nxt.rdata[sideband_pkg::WAKE_POL_BIT] = st_r.wake_pol;
            end else if (ADDR_I == sideband_pkg::CHIP_CONFIG_REG_ADDR) begin
                st_nxt.rdata[sideband_pkg::STRAP_BIT] = st_r.strap;
            end else if (ADDR_I == sideband_pkg::BUS_SPEED_REG_ADDR) begin
                st_nxt.rdata[1:0] = st_r.bus_speed;
            end else if (ADDR_I == sideband_pkg::IRQ_MASK_REG_ADDR) begin
                st_nxt.rdata[sideband_pkg::IRQ_W-1:0] = st_r.irq_mask;
            end else if (ADDR_I == sideband_pkg::IRQ_STATUS_REG_ADDR) begin
                st_nxt.rdata[sideband_pkg::IRQ_W-1:0] = st_r.irq_stat;
            end else if (ADDR_I == sideband_pkg::ROM_CTRL_REG_ADDR) begin
                st_nxt.rdata[sideband_pkg::ROM_BUSY_BIT] = st_r.rom_st != sideband_pkg::ROM_IDLE;
            end else if (ADDR_I == sideband_pkg::ROM_DATA_REG_ADDR) begin
                st_nxt.rdata = st_r.rom_in;
            end
        end

        st_nxt.rom_cs = st_nxt.rom_st != sideband_pkg::ROM_IDLE;
        st_nxt.rom_do = st_nxt.rom_cs && st_nxt.rom_shift[sideband_pkg::ROM_OUT_LEN-1];
        st_nxt.rom_oe = st_nxt.rom_cs && (st_nxt.rom_bits > sideband_pkg::ROM_IN_BITS);

        if (st_r.led_sel) begin
            st_nxt.second_ind_n = !act_lit;
            st_nxt.first_ind_n = !LINK_UP_I;
        end else begin
            st_nxt.second_ind_n = !speed_lit;
            st_nxt.first_ind_n = !link_act_lit;
        end
        wake_on = st_r.irq_stat[sideband_pkg::IRQ_WAKE_BIT];
        st_nxt.wake_out = st_r.wake_pol ? wake_on : !wake_on;
        st_nxt.irq_n = !(|(st_r.irq_stat & st_r.irq_mask));

        if (RST_I) begin
            // Synchroniser keeps running so the strap is the pin level just before release.
            st_nxt.strap = st_r.sync2;
            st_nxt.led_sel = sideband_pkg::LED_SEL_RST;
            st_nxt.wake_pol = sideband_pkg::WAKE_POL_RST;
            st_nxt.bus_speed = sideband_pkg::BUS_SPEED_RST;
            st_nxt.irq_stat = '0;
            st_nxt.irq_mask = sideband_pkg::IRQ_MASK_RST;
            st_nxt.rdata = '0;
            st_nxt.act_timer = '0;
            st_nxt.rom_st = sideband_pkg::ROM_IDLE;
            st_nxt.rom_half = '0;
            st_nxt.rom_bits = '0;
            st_nxt.rom_shift = '0;
            st_nxt.rom_in = '0;
            st_nxt.rom_sk = 1'b0;
            st_nxt.rom_do = 1'b0;
            st_nxt.rom_oe = 1'b0;
            st_nxt.rom_cs = 1'b0;
            st_nxt.first_ind_n = 1'b1;
            st_nxt.second_ind_n = 1'b1;
            st_nxt.wake_out = !sideband_pkg::WAKE_POL_RST;
            st_nxt.irq_n = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        st_r <= st_nxt;
    end

    assign RDATA_O = st_r.rdata;
    assign FIRST_INDICATOR_OUT_N_O = st_r.first_ind_n;
    assign SECOND_INDICATOR_OUT_N_O = st_r.second_ind_n;
    assign WAKE_EVENT_OUT_O = st_r.wake_out;
    assign HOST_IRQ_N_O = st_r.irq_n;
    assign ROM_DATA_IO_O = st_r.rom_do;
    assign ROM_DATA_IO_OE_O = st_r.rom_oe;
    assign ROM_SERIAL_CLK_O = st_r.rom_sk;
    assign ROM_SELECT_O = st_r.rom_cs;
endmodule : status_sideband

/* hw/sideband_pkg.sv */
package sideband_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    localparam logic [7:0] GLOBAL_CONTROL_REG_ADDR = 8'hc6;
    localparam logic [7:0] POWER_EVENT_CONTROL_REG_ADDR = 8'hd4;
    localparam logic [7:0] CHIP_CONFIG_REG_ADDR = 8'h48;
    localparam logic [7:0] BUS_SPEED_REG_ADDR = 8'h20;
    localparam logic [7:0] IRQ_MASK_REG_ADDR = 8'h90;
    localparam logic [7:0] IRQ_STATUS_REG_ADDR = 8'h92;
    localparam logic [7:0] ROM_CTRL_REG_ADDR = 8'h50;
    localparam logic [7:0] ROM_DATA_REG_ADDR = 8'h52;

    localparam int LED_SEL_BIT = 9;
    localparam int STRAP_BIT = 9;
    localparam int WAKE_POL_BIT = 4;
    localparam int IRQ_W = 3;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_LINK_BIT = 1;
    localparam int IRQ_ROM_BIT = 2;
    localparam int ROM_START_BIT = 15;
    localparam int ROM_BUSY_BIT = 14;

    localparam logic LED_SEL_RST = 1'b0;
    localparam logic WAKE_POL_RST = 1'b0;
    localparam logic [1:0] BUS_SPEED_RST = 2'b11;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    localparam logic [1:0] BUS_SPEED_FAST = 2'b00;
    localparam int ROM_SK_SLOW_NS = 4000;
    localparam int ROM_SK_FAST_NS = 800;
    localparam logic [8:0] ROM_HALF_SLOW = 9'(ROM_SK_SLOW_NS / (2 * CLK_PERIOD_NS));
    localparam logic [8:0] ROM_HALF_FAST = 9'(ROM_SK_FAST_NS / (2 * CLK_PERIOD_NS));
    localparam int ROM_OUT_LEN = 11;
    localparam int ROM_IN_LEN = 16;
    localparam logic [4:0] ROM_IN_BITS = 5'(ROM_IN_LEN);
    localparam logic [4:0] ROM_TOTAL_BITS = 5'(ROM_OUT_LEN + ROM_IN_LEN);

    localparam int BLINK_HALF_MS = 40;
    localparam logic [23:0] BLINK_HALF_CYC = 24'(BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        ROM_IDLE = 2'b00,
        ROM_LOW = 2'b01,
        ROM_HIGH = 2'b11
    } rom_state_e;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic strap;
        logic led_sel;
        logic wake_pol;
        logic [1:0] bus_speed;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        logic link_d;
        logic [23:0] act_timer;
        rom_state_e rom_st;
        logic [8:0] rom_half;
        logic [4:0] rom_bits;
        logic [ROM_OUT_LEN-1:0] rom_shift;
        logic [ROM_IN_LEN-1:0] rom_in;
        logic rom_sk;
        logic rom_do;
        logic rom_oe;
        logic rom_cs;
        logic first_ind_n;
        logic second_ind_n;
        logic wake_out;
        logic irq_n;
    } sideband_state_s;
endpackage : sideband_pkg

/* testbench/sideband_properties.sv */
`timescale 1ns/100ps
module sideband_props (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic LINK_UP_I,
    input wire logic WOL_EVENT_I,
    input wire logic FIRST_INDICATOR_OUT_N_O,
    input wire logic SECOND_INDICATOR_OUT_N_O,
    input wire logic WAKE_EVENT_OUT_O,
    input wire logic HOST_IRQ_N_O,
    input wire logic ROM_DATA_IO_OE_O,
    input wire logic ROM_SERIAL_CLK_O,
    input wire logic ROM_SELECT_O
);
    logic [8:0] hi_cnt_r;
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);
    // Counts high cycles of the serial clock so a half period can be measured exactly.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || !ROM_SERIAL_CLK_O) begin
            hi_cnt_r <= 9'h0;
        end else begin
            hi_cnt_r <= hi_cnt_r + 9'h1;
        end
    end
    a_reset_quiet: assert property (disable iff (1'b0) RST_I |=>
        FIRST_INDICATOR_OUT_N_O && SECOND_INDICATOR_OUT_N_O && HOST_IRQ_N_O && WAKE_EVENT_OUT_O)
        else $error("outputs active in reset");
    a_read_quiet: assert property (!$past(RD_I) |-> RDATA_O == 16'h0)
        else $error("read data outside read cycle");
    a_irq_release: assert property ($rose(HOST_IRQ_N_O) |-> $past(WR_I, 2))
        else $error("irq released without write");
    a_wake_cause: assert property ($changed(WAKE_EVENT_OUT_O) |->
        $past(WOL_EVENT_I, 2) || $past(WR_I, 2)) else $error("wake changed without cause");
    a_link_dark: assert property (!LINK_UP_I |=> FIRST_INDICATOR_OUT_N_O)
        else $error("first led lit without link");
    a_cs_start: assert property ($rose(ROM_SELECT_O) |-> $past(WR_I) && $past(WDATA_I[15])
        && $past(ADDR_I) == sideband_pkg::ROM_CTRL_REG_ADDR) else $error("rom select unasked");
    a_oe_head: assert property ($rose(ROM_SELECT_O) |-> ROM_DATA_IO_OE_O)
        else $error("rom frame not driving");
    a_clk_parked: assert property (!ROM_SELECT_O |-> !ROM_SERIAL_CLK_O && !ROM_DATA_IO_OE_O)
        else $error("rom clock outside frame");
    a_half_len: assert property ($fell(ROM_SERIAL_CLK_O) |->
        hi_cnt_r == sideband_pkg::ROM_HALF_FAST || hi_cnt_r == sideband_pkg::ROM_HALF_SLOW)
        else $error("rom clock half period wrong");
    c_rom_frame: cover property ($rose(ROM_SELECT_O));
    c_irq_low: cover property ($fell(HOST_IRQ_N_O));
    c_wake: cover property ($changed(WAKE_EVENT_OUT_O));
endmodule : sideband_props
bind status_sideband sideband_props chk (.CORE_CLK_I, .RST_I,
    .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .LINK_UP_I, .WOL_EVENT_I, .FIRST_INDICATOR_OUT_N_O,
    .SECOND_INDICATOR_OUT_N_O, .WAKE_EVENT_OUT_O, .HOST_IRQ_N_O, .ROM_DATA_IO_OE_O,
    .ROM_SERIAL_CLK_O, .ROM_SELECT_O);

/* testbench/rom_model.sv */
`timescale 1ns/100ps
module rom_model #(
    parameter logic [15:0] WORD = 16'h0
) (
    input wire logic sk_i, // Serial clock.
    input wire logic cs_i, // Chip select.
    input wire logic oe_i, // Device drives the line.
    input wire logic do_i, // Device drive value.
    input wire logic pull_i, // Board strap pull level.
    output logic pin_o, // Resolved line level.
    output logic [10:0] cmd_o // Bits shifted in.
);
    int n = 0;
    logic q = 1'b0;
    always @(posedge sk_i or posedge cs_i) begin
        if (!sk_i) begin
            n <= 0;
        end else begin
            if (n < 11) begin
                cmd_o <= {cmd_o[9:0], do_i};
            end
            n <= n + 1;
        end
    end
    always @(negedge sk_i) begin
        if (n >= 11 && n < 27) begin
            q <= WORD[26-n];
        end
    end
    // A released line carries the ROM bit while selected, else the strap pull, never the last bit sent.
    assign pin_o = oe_i ? do_i : (cs_i ? q : pull_i);
endmodule : rom_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    localparam logic [23:0] BH = 24'h8;
    localparam logic [15:0] ROM_WORD = 16'hc35a;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic link = 1'b0;
    logic spd = 1'b0;
    logic act = 1'b0;
    logic wol = 1'b0;
    logic pull = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [15:0] wdata = 16'h0;
    logic [15:0] rdata;
    logic [10:0] cmd, cmd_seen;
    logic first_n, second_n, wake, irq_n, pin, dout, oe, sk, cs;
    logic [23:0] steps [5] = '{24'h900000, 24'hd40010, 24'h920001, 24'hd40000, 24'h900002};
    int bad_count = 0;
    int n_tests = 0;
    int seed = 32'hda7c;
    int n, ref_sel, ref_pol, ref_mask, ref_stat;
    initial begin
        forever #5 clk = ~clk;
    end
    status_sideband #(.BLINK_HALF(BH)) uut (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .LINK_UP_I(link),
        .SPEED100_I(spd), .ACTIVITY_I(act), .WOL_EVENT_I(wol), .FIRST_INDICATOR_OUT_N_O(first_n),
        .SECOND_INDICATOR_OUT_N_O(second_n), .WAKE_EVENT_OUT_O(wake), .HOST_IRQ_N_O(irq_n),
        .ROM_DATA_IO_I(pin), .ROM_DATA_IO_O(dout), .ROM_DATA_IO_OE_O(oe),
        .ROM_SERIAL_CLK_O(sk), .ROM_SELECT_O(cs));
    rom_model #(.WORD(ROM_WORD)) rom (.sk_i(sk), .cs_i(cs), .oe_i(oe), .do_i(dout),
        .pull_i(pull), .pin_o(pin), .cmd_o(cmd_seen));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // With the blink timer idle, the link/activity LED simply follows the link.
    task automatic chk_pins();
        chk("first_n", 16'(!link), 16'(first_n));
        chk("second_n", 16'(ref_sel == 1 || !(link && spd)), 16'(second_n));
        chk("irq_n", 16'((ref_stat & ref_mask) == 0), 16'(irq_n));
        chk("wake", 16'(ref_stat[0] == ref_pol[0]), 16'(wake));
    endtask : chk_pins
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        case (a)
            sideband_pkg::GLOBAL_CONTROL_REG_ADDR: ref_sel = int'(d[9]);
            sideband_pkg::POWER_EVENT_CONTROL_REG_ADDR: ref_pol = int'(d[4]);
            sideband_pkg::IRQ_MASK_REG_ADDR: ref_mask = int'(d[2:0]);
            sideband_pkg::IRQ_STATUS_REG_ADDR: ref_stat &= ~int'(d[2:0]);
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk($sformatf("rdata %h", a), e, rdata);
    endtask : rd
    task automatic do_reset(input logic p);
        @(posedge clk);
        pull <= p;
        link <= 1'b0;
        rst <= 1'b1;
        {ref_sel, ref_pol, ref_mask, ref_stat} = '0;
        tick(2);
        chk_pins();
        @(posedge clk);
        rst <= 1'b0;
        rd(sideband_pkg::CHIP_CONFIG_REG_ADDR, 16'(p) << 9);
        rd(sideband_pkg::GLOBAL_CONTROL_REG_ADDR, 16'h0);
        rd(sideband_pkg::POWER_EVENT_CONTROL_REG_ADDR, 16'h0);
        rd(sideband_pkg::BUS_SPEED_REG_ADDR, 16'h3);
        rd(8'h00, 16'h0);
        $display("test reset done");
    endtask : do_reset
    initial begin
        #600000;
        bad_count++;
        summarize();
    end
    initial begin
        do_reset(1'b1);
        for (int s = 0; s < 2; s++) begin
            wr(sideband_pkg::GLOBAL_CONTROL_REG_ADDR, 16'(s) << 9);
            repeat (6) begin
                @(posedge clk);
                link <= 1'($random(seed));
                spd <= 1'($random(seed));
                tick(3);
                chk_pins();
            end
            @(posedge clk);
            link <= 1'b1;
            tick(3);
            @(posedge clk);
            act <= 1'b1;
            @(posedge clk);
            act <= 1'b0;
            n = 0;
            repeat (30) begin
                tick(1);
                n += (s == 1) ? int'(!second_n) : int'(first_n);
            end
            chk("blink", BH[15:0], 16'(n));
        end
        $display("test leds done");
        wr(sideband_pkg::IRQ_STATUS_REG_ADDR, 16'h7);
        wr(sideband_pkg::IRQ_MASK_REG_ADDR, 16'h1);
        @(posedge clk);
        wol <= 1'b1;
        @(posedge clk);
        wol <= 1'b0;
        ref_stat |= 1;
        tick(2);
        chk_pins();
        foreach (steps[i]) begin
            wr(steps[i][23:16], steps[i][15:0]);
            tick(2);
            chk_pins();
        end
        @(posedge clk);
        link <= !link;
        ref_stat |= 2;
        tick(3);
        chk_pins();
        rd(sideband_pkg::IRQ_STATUS_REG_ADDR, 16'(ref_stat));
        wr(sideband_pkg::IRQ_STATUS_REG_ADDR, 16'h2);
        tick(2);
        chk_pins();
        $display("test irq done");
        for (int s = 0; s < 2; s++) begin
            cmd = 11'($random(seed));
            wr(sideband_pkg::BUS_SPEED_REG_ADDR, (s == 1) ? 16'h0 : 16'h3);
            wr(sideband_pkg::ROM_CTRL_REG_ADDR, {5'h10, cmd});
            rd(sideband_pkg::ROM_CTRL_REG_ADDR, 16'h4000);
            // A start inside a running frame must be dropped, or the model sees a new command.
            wr(sideband_pkg::ROM_CTRL_REG_ADDR, {5'h10, ~cmd});
            n = 4;
            #1;
            while (cs === 1'b1 && n < 20000) begin
                tick(1);
                n++;
            end
            chk("rom frame", 16'(54 * ((s == 1) ? 40 : 200)), 16'(n));
            chk("rom cmd", 16'(cmd), 16'(cmd_seen));
            rd(sideband_pkg::ROM_DATA_REG_ADDR, ROM_WORD);
            ref_stat |= 4;
            rd(sideband_pkg::IRQ_STATUS_REG_ADDR, 16'(ref_stat));
            wr(sideband_pkg::IRQ_STATUS_REG_ADDR, 16'h4);
        end
        $display("test rom done");
        do_reset(1'b0);
        summarize();
    end
endmodule : tb_top
